// >>> tad_consts.svh
/*
 * Holds the named offsets, field positions, reset values and address windows
 * of the alias and debug configuration block.
 * Assumes it is included by its bare name from each design file that needs it.
 */
`ifndef TAD_CONSTS_SVH
`define TAD_CONSTS_SVH

// ==========================================================================
// Register offsets on the plain register port.
// ==========================================================================
`define TAD_REG_CTRL 8'h00
`define TAD_REG_STATUS 8'h04
`define TAD_REG_CFG 8'h08
`define TAD_REG_BP0 8'h10
`define TAD_REG_WP0 8'h20
`define TAD_BP_IDX_MSB 3
`define TAD_BP_IDX_LSB 2
`define TAD_BP_MASK 8'hF0
`define TAD_WP_MASK 8'hF8

// ==========================================================================
// Field positions.
// ==========================================================================
`define TAD_WP_LSB 4
`define TAD_CFG_SMALL 2
`define TAD_CFG_DBG_LSB 3
`define TAD_CFG_NBP_LSB 8
`define TAD_CFG_NWP_LSB 12

// ==========================================================================
// Comparator counts and memory limits.
// ==========================================================================
`define TAD_BP_FULL 4
`define TAD_WP_FULL 2
`define TAD_BP_SMALL 2
`define TAD_WP_SMALL 1
`define TAD_TCM_MIN_KB 8
`define TAD_TCM_MAX_KB 1024
`define TAD_WORDS_PER_KB 256
`define TAD_BYTES_PER_KB 1024

// ==========================================================================
// Alias windows and reset values.
// ==========================================================================
`define TAD_LOWER_BASE 32'h0000_0000
`define TAD_UPPER_BASE 32'h1000_0000
`define TAD_ZERO32 32'h0000_0000
`define TAD_ALIAS_LOWER 0
`define TAD_ALIAS_UPPER 1

`endif

// >>> tad_pkg.sv
/*
 * Holds the types of the alias and debug configuration block.
 * Assumes nothing of its surroundings; constants live in tad_consts.svh.
 */
package tad_pkg;

	// ======================================================================
	// Debug port build choice.
	// ======================================================================
	typedef enum logic [1:0] {
		TAD_DBG_JTAG = 2'h0,
		TAD_DBG_SW = 2'h1,
		TAD_DBG_BOTH = 2'h2,
		TAD_DBG_NONE = 2'h3
	} tad_dbg_sel_t;

	// ======================================================================
	// Fetch sequencer states, one-hot.
	// ======================================================================
	typedef enum logic [2:0] {
		TAD_F_IDLE = 3'h1,
		TAD_F_TCM = 3'h2,
		TAD_F_EXT = 3'h4
	} tad_fetch_st_t;

endpackage

// >>> tad_tcm_mem.sv
/*
 * Holds the instruction tight memory: one word array with a registered read
 * port and a write port.
 * Assumes word addresses already lie inside the array.
 */
`timescale 1ns/1ns

module tad_tcm_mem #(
	parameter int WORDS = 2048,
	parameter int AW = 11
) (
	input wire logic i_sys_clk,
	input wire logic i_rd_en,
	input wire logic [AW-1:0] i_rd_idx,
	output logic [31:0] o_rd_data,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_idx,
	input wire logic [31:0] i_wr_data
);

	logic [31:0] mem [WORDS];
	logic [31:0] rd_d;
	logic [31:0] rd_q;

	// Holds the read word when no read is asked for.
	always_comb begin
		rd_d = rd_q;
		if (i_rd_en) begin
			rd_d = mem[i_rd_idx];
		end
	end

	// Registers the read word and stores any write.
	always_ff @(posedge i_sys_clk) begin
		rd_q <= rd_d;
		if (i_wr_en) begin
			mem[i_wr_idx] <= i_wr_data;
		end
	end

	assign o_rd_data = rd_q;

endmodule

// >>> tad_core_cfg.sv
/*
 * Holds the top of the alias and debug configuration block: alias latch,
 * fetch routing between tight memory and the external port, store path into
 * tight memory, and the debug comparators with their register port.
 * Assumes a single 25 MHz clock, a synchronous active-high reset, and an
 * external fetch port that answers each request with one ack pulse.
 */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "tad_consts.svh"

// Overview of operation
// - The build picks one debug port choice: JTAG, serial wire, both, or none.
// - Full debug gives four breakpoint and two watchpoint comparators.
// - Small debug gives two breakpoint and one watchpoint comparator.
// - With no debug, every debug output is held idle and no debug access is offered.
// - With no debug, the small debug option is ignored.
// - The tight memory size is a build choice from 8KB to 1MB.
// - The active aliases follow the alias enable input while reset is held.
// - The lower and upper aliases are enabled independently.
// - Fetches from tight memory finish sooner than external fetches.
module tad_core_cfg #(
	parameter tad_pkg::tad_dbg_sel_t DBG_SEL = tad_pkg::TAD_DBG_BOTH,
	parameter bit SMALL_DEBUG = 1'b0,
	parameter int TCM_KB = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_tcm_alias_enable_cfg,
	input wire logic i_fetch_req,
	input wire logic [31:0] i_fetch_addr,
	output logic o_fetch_ready,
	output logic o_fetch_valid,
	output logic [31:0] o_fetch_data,
	output logic o_ext_req,
	output logic [31:0] o_ext_addr,
	input wire logic i_ext_ack,
	input wire logic [31:0] i_ext_data,
	input wire logic i_st_req,
	input wire logic [31:0] i_st_addr,
	input wire logic [31:0] i_st_data,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_dbg_halted,
	output logic o_dbg_jtag_en,
	output logic o_dbg_sw_en
);

	// ======================================================================
	// Build-time sizing.
	// ======================================================================
	localparam bit HAS_DBG = (DBG_SEL != tad_pkg::TAD_DBG_NONE);
	localparam bit SMALL = HAS_DBG && SMALL_DEBUG;
	localparam int NBP = !HAS_DBG ? 0 : (SMALL ? `TAD_BP_SMALL : `TAD_BP_FULL);
	localparam int NWP = !HAS_DBG ? 0 : (SMALL ? `TAD_WP_SMALL : `TAD_WP_FULL);
	localparam int KB = (TCM_KB < `TAD_TCM_MIN_KB) ? `TAD_TCM_MIN_KB :
		((TCM_KB > `TAD_TCM_MAX_KB) ? `TAD_TCM_MAX_KB : TCM_KB);
	localparam int WORDS = KB * `TAD_WORDS_PER_KB;
	localparam int AW = $clog2(WORDS);
	localparam logic [31:0] SPAN = 32'(KB * `TAD_BYTES_PER_KB);

	// Tells whether an address falls in an alias window of the tight memory.
	function automatic logic in_win(input logic [31:0] a, input logic [31:0] base);
		in_win = (a >= base) && ((a - base) < SPAN);
	endfunction

	// Tells whether an address hits any alias that is switched on.
	function automatic logic tcm_hit(input logic [31:0] a, input logic [1:0] en);
		tcm_hit = (en[`TAD_ALIAS_LOWER] && in_win(a, `TAD_LOWER_BASE)) ||
			(en[`TAD_ALIAS_UPPER] && in_win(a, `TAD_UPPER_BASE));
	endfunction

	// ======================================================================
	// Alias latch.
	// ======================================================================
	logic [1:0] alias_d;
	logic [1:0] alias_q;

	// Follows the strap while reset is held and freezes at release.
	always_comb begin
		alias_d = i_srst ? i_tcm_alias_enable_cfg : alias_q;
	end

	always_ff @(posedge i_sys_clk) begin
		alias_q <= alias_d;
	end

	// ======================================================================
	// Fetch sequencer.
	// ======================================================================
	tad_pkg::tad_fetch_st_t st_d;
	tad_pkg::tad_fetch_st_t st_q;
	logic rdy_d, rdy_q, fv_d, fv_q, xr_d, xr_q;
	logic [31:0] fd_d, fd_q, xa_d, xa_q;
	logic take;
	logic tcm_rd;
	logic st_wr;
	logic [31:0] mem_q;

	assign take = i_fetch_req && (st_q == tad_pkg::TAD_F_IDLE);
	assign tcm_rd = take && tcm_hit(i_fetch_addr, alias_q);
	assign st_wr = i_st_req && tcm_hit(i_st_addr, alias_q);

	// Routes a taken fetch to tight memory or the external port.
	always_comb begin
		st_d = st_q;
		fv_d = 1'b0;
		fd_d = fd_q;
		xr_d = xr_q;
		xa_d = xa_q;
		case (st_q)
			tad_pkg::TAD_F_IDLE: begin
				if (tcm_rd) begin
					st_d = tad_pkg::TAD_F_TCM;
				end else if (take) begin
					st_d = tad_pkg::TAD_F_EXT;
					xr_d = 1'b1;
					xa_d = i_fetch_addr;
				end
			end
			tad_pkg::TAD_F_TCM: begin
				fd_d = mem_q;
				fv_d = 1'b1;
				st_d = tad_pkg::TAD_F_IDLE;
			end
			tad_pkg::TAD_F_EXT: begin
				if (i_ext_ack) begin
					fd_d = i_ext_data;
					fv_d = 1'b1;
					xr_d = 1'b0;
					st_d = tad_pkg::TAD_F_IDLE;
				end
			end
			default: begin
				st_d = tad_pkg::TAD_F_IDLE;
			end
		endcase
		if (i_srst) begin
			st_d = tad_pkg::TAD_F_IDLE;
			fv_d = 1'b0;
			fd_d = `TAD_ZERO32;
			xr_d = 1'b0;
			xa_d = `TAD_ZERO32;
		end
		rdy_d = (st_d == tad_pkg::TAD_F_IDLE);
	end

	always_ff @(posedge i_sys_clk) begin
		st_q <= st_d;
		rdy_q <= rdy_d;
		fv_q <= fv_d;
		fd_q <= fd_d;
		xr_q <= xr_d;
		xa_q <= xa_d;
	end

	// Tight memory sized from the build choice.
	tad_tcm_mem #(
		.WORDS(WORDS),
		.AW(AW)
	) tad_tcm_mem_i (
		.i_sys_clk(i_sys_clk),
		.i_rd_en(tcm_rd),
		.i_rd_idx(i_fetch_addr[AW+1:2]),
		.o_rd_data(mem_q),
		.i_wr_en(st_wr),
		.i_wr_idx(i_st_addr[AW+1:2]),
		.i_wr_data(i_st_data)
	);

	// ======================================================================
	// Debug comparators and register port.
	// ======================================================================
	logic [3:0] bpen_d, bpen_q, bph_d, bph_q, bpm;
	logic [1:0] wpen_d, wpen_q, wph_d, wph_q, wpm;
	logic [31:0] bpa_d [`TAD_BP_FULL];
	logic [31:0] bpa_q [`TAD_BP_FULL];
	logic [31:0] wpa_d [`TAD_WP_FULL];
	logic [31:0] wpa_q [`TAD_WP_FULL];
	logic [31:0] rd_d, rd_q, cfgw;
	logic hlt_d, hlt_q;
	logic [1:0] bpi;

	assign bpi = i_reg_addr[`TAD_BP_IDX_MSB:`TAD_BP_IDX_LSB];
	assign cfgw = {16'h0000, 4'(NWP), 4'(NBP), 3'h0, 2'(DBG_SEL), 1'(SMALL), alias_q};

	// Compares fetch and store addresses against the built comparators only.
	always_comb begin
		bpm = 4'h0;
		wpm = 2'h0;
		for (int i = 0; i < NBP; i++) begin
			bpm[i] = take && bpen_q[i] && (i_fetch_addr == bpa_q[i]);
		end
		for (int i = 0; i < NWP; i++) begin
			wpm[i] = i_st_req && wpen_q[i] && (i_st_addr == wpa_q[i]);
		end
	end

	// Decodes register writes; a new hit wins over a clear in the same cycle.
	always_comb begin
		bpen_d = bpen_q;
		wpen_d = wpen_q;
		bph_d = bph_q;
		wph_d = wph_q;
		bpa_d = bpa_q;
		wpa_d = wpa_q;
		if (HAS_DBG && i_reg_wr) begin
			if (i_reg_addr == `TAD_REG_CTRL) begin
				bpen_d = i_reg_wdata[3:0];
				wpen_d = i_reg_wdata[`TAD_WP_LSB+1:`TAD_WP_LSB];
			end else if (i_reg_addr == `TAD_REG_STATUS) begin
				bph_d = bph_q & ~i_reg_wdata[3:0];
				wph_d = wph_q & ~i_reg_wdata[`TAD_WP_LSB+1:`TAD_WP_LSB];
			end else if ((i_reg_addr & `TAD_BP_MASK) == `TAD_REG_BP0) begin
				bpa_d[bpi] = i_reg_wdata;
			end else if ((i_reg_addr & `TAD_WP_MASK) == `TAD_REG_WP0) begin
				wpa_d[i_reg_addr[2]] = i_reg_wdata;
			end
		end
		bph_d = bph_d | bpm;
		wph_d = wph_d | wpm;
		hlt_d = |bph_d;
		rd_d = `TAD_ZERO32;
		if (i_reg_rd) begin
			if (i_reg_addr == `TAD_REG_CFG) begin
				rd_d = cfgw;
			end else if (!HAS_DBG) begin
				rd_d = `TAD_ZERO32;
			end else if (i_reg_addr == `TAD_REG_CTRL) begin
				rd_d = {26'h0, wpen_q, bpen_q};
			end else if (i_reg_addr == `TAD_REG_STATUS) begin
				rd_d = {26'h0, wph_q, bph_q};
			end else if ((i_reg_addr & `TAD_BP_MASK) == `TAD_REG_BP0) begin
				rd_d = bpa_q[bpi];
			end else if ((i_reg_addr & `TAD_WP_MASK) == `TAD_REG_WP0) begin
				rd_d = wpa_q[i_reg_addr[2]];
			end
		end
		if (i_srst) begin
			bpen_d = 4'h0;
			wpen_d = 2'h0;
			bph_d = 4'h0;
			wph_d = 2'h0;
			hlt_d = 1'b0;
			rd_d = `TAD_ZERO32;
			for (int i = 0; i < `TAD_BP_FULL; i++) begin
				bpa_d[i] = `TAD_ZERO32;
			end
			for (int i = 0; i < `TAD_WP_FULL; i++) begin
				wpa_d[i] = `TAD_ZERO32;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		bpen_q <= bpen_d;
		wpen_q <= wpen_d;
		bph_q <= bph_d;
		wph_q <= wph_d;
		bpa_q <= bpa_d;
		wpa_q <= wpa_d;
		hlt_q <= hlt_d;
		rd_q <= rd_d;
	end

	// Port-present flags come from flops so they too are quiet in reset.
	logic jt_d, jt_q, sw_d, sw_q;

	always_comb begin
		jt_d = !i_srst && (DBG_SEL == tad_pkg::TAD_DBG_JTAG
			|| DBG_SEL == tad_pkg::TAD_DBG_BOTH);
		sw_d = !i_srst && (DBG_SEL == tad_pkg::TAD_DBG_SW
			|| DBG_SEL == tad_pkg::TAD_DBG_BOTH);
	end

	// Registers the port-present flags.
	always_ff @(posedge i_sys_clk) begin
		jt_q <= jt_d;
		sw_q <= sw_d;
	end

	assign o_fetch_ready = rdy_q;
	assign o_fetch_valid = fv_q;
	assign o_fetch_data = fd_q;
	assign o_ext_req = xr_q;
	assign o_ext_addr = xa_q;
	assign o_reg_rdata = rd_q;
	assign o_dbg_halted = hlt_q;
	assign o_dbg_jtag_en = jt_q;
	assign o_dbg_sw_en = sw_q;

endmodule

// >>> tad_core_cfg_checker.sv
/* Concurrent checks on the ports of tad_core_cfg.
   Assumes one clock, a synchronous active-high reset and a bind from the bench. */
`timescale 1ns/1ns

module tad_core_cfg_checker #(
	parameter tad_pkg::tad_dbg_sel_t DBG_SEL = tad_pkg::TAD_DBG_BOTH,
	parameter int TCM_KB = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_tcm_alias_enable_cfg,
	input wire logic i_fetch_req,
	input wire logic [31:0] i_fetch_addr,
	input wire logic o_fetch_ready,
	input wire logic o_fetch_valid,
	input wire logic [31:0] o_fetch_data,
	input wire logic o_ext_req,
	input wire logic [31:0] o_ext_addr,
	input wire logic i_ext_ack,
	input wire logic [31:0] i_ext_data,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_dbg_halted,
	input wire logic o_dbg_jtag_en,
	input wire logic o_dbg_sw_en
);
	// ==============================
	// Alias mirror
	localparam logic [31:0] WIN = TCM_KB * 1024;
	logic [1:0] strap_d;
	logic [1:0] strap_q;
	logic hit;
	logic take;
	// The strap is followed while reset is held and frozen after it.
	assign strap_d = i_srst ? i_tcm_alias_enable_cfg : strap_q;
	assign take = i_fetch_req && o_fetch_ready;
	assign hit = (strap_q[0] && i_fetch_addr < WIN) || (strap_q[1]
		&& i_fetch_addr >= 32'h1000_0000 && i_fetch_addr < 32'h1000_0000 + WIN);
	// Registers the mirrored strap.
	always_ff @(posedge i_sys_clk) begin
		strap_q <= strap_d;
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	// ==============================
	// Port relations
	property p_tcm_lat;
		take && hit |=> !o_fetch_valid && !o_ext_req ##1 o_fetch_valid;
	endproperty
	a_tcm_lat: assert property (p_tcm_lat) else $error("tight fetch latency wrong");
	property p_ext_go;
		take && !hit |=> o_ext_req && o_ext_addr == $past(i_fetch_addr);
	endproperty
	a_ext_go: assert property (p_ext_go) else $error("external fetch not issued");
	property p_ext_ret;
		o_ext_req && i_ext_ack |=> o_fetch_valid && !o_ext_req && o_fetch_data == $past(i_ext_data);
	endproperty
	a_ext_ret: assert property (p_ext_ret) else $error("external answer lost");
	property p_ext_wait;
		o_ext_req && !i_ext_ack |=> o_ext_req && !o_fetch_valid;
	endproperty
	a_ext_wait: assert property (p_ext_wait) else $error("external fetch ended early");
	property p_busy;
		take |=> !o_fetch_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready kept while busy");
	property p_cfg_rd;
		i_reg_rd && i_reg_addr == 8'h08 |=> o_reg_rdata[1:0] == strap_q && o_reg_rdata[4:3] == DBG_SEL;
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("configuration read wrong");
	property p_ports;
		!$past(i_srst) |-> o_dbg_jtag_en == (DBG_SEL inside {tad_pkg::TAD_DBG_JTAG,
			tad_pkg::TAD_DBG_BOTH}) && o_dbg_sw_en == (DBG_SEL inside {tad_pkg::TAD_DBG_SW,
			tad_pkg::TAD_DBG_BOTH});
	endproperty
	a_ports: assert property (p_ports) else $error("debug port enables wrong");
	property p_halt;
		$rose(o_dbg_halted) |-> $past(take);
	endproperty
	a_halt: assert property (p_halt) else $error("halt without a taken fetch");
endmodule

// >>> tad_ext_mem.sv
/* Model of the external memory behind the fetch port.
   Assumes a request level held until one cycle after its ack. */
`timescale 1ns/1ns

module tad_ext_mem (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire logic [31:0] i_addr,
	input wire logic [3:0] i_wait,
	output logic o_ack,
	output logic [31:0] o_data
);
	logic [3:0] cnt_q = 4'h0;
	// Acks after i_wait cycles; data is the inverted address and toggles on every cycle without an ack.
	always @(posedge i_sys_clk) begin
		if (i_req && !o_ack && cnt_q >= i_wait) begin
			o_ack <= 1'b1;
			o_data <= ~i_addr;
			cnt_q <= 4'h0;
		end else begin
			o_ack <= 1'b0;
			o_data <= ~o_data;
			cnt_q <= (i_req && !o_ack) ? cnt_q + 4'h1 : 4'h0;
		end
	end
	initial begin
		o_ack = 1'b0;
		o_data = 32'h0;
	end
endmodule

// >>> tb_tad_core_cfg.sv
/* Self-checking bench for tad_core_cfg with an 8KB tight memory.
   Assumes tad_ext_mem and the bound checker. */
`timescale 1ns/1ns

module tb_tad_core_cfg;
	logic i_sys_clk, i_srst, i_fetch_req, i_ext_ack, i_st_req, i_reg_wr, i_reg_rd;
	logic o_fetch_ready, o_fetch_valid, o_ext_req, o_dbg_halted, o_dbg_jtag_en, o_dbg_sw_en;
	logic [1:0] i_tcm_alias_enable_cfg;
	logic [7:0] i_reg_addr;
	logic [3:0] ext_wait;
	logic [31:0] i_fetch_addr, o_fetch_data, o_ext_addr, i_ext_data, i_st_addr, i_st_data;
	logic [31:0] i_reg_wdata, o_reg_rdata;
	logic [31:0] sm_rdata, nd_rdata;
	logic sm_halted, sm_jtag, sm_sw, nd_halted, nd_jtag, nd_sw;
	int fails, n_checks, cyc;

	tad_core_cfg #(.TCM_KB(8)) tad_core_cfg_i (.i_sys_clk, .i_srst, .i_tcm_alias_enable_cfg,
		.i_fetch_req, .i_fetch_addr, .o_fetch_ready, .o_fetch_valid, .o_fetch_data, .o_ext_req,
		.o_ext_addr, .i_ext_ack, .i_ext_data, .i_st_req, .i_st_addr, .i_st_data, .i_reg_addr,
		.i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_dbg_halted, .o_dbg_jtag_en,
		.o_dbg_sw_en);
	tad_ext_mem tad_ext_mem_i (.i_sys_clk, .i_req(o_ext_req), .i_addr(o_ext_addr),
		.i_wait(ext_wait), .o_ack(i_ext_ack), .o_data(i_ext_data));
	// Small serial-only build and no-debug build share every input with the main one.
	tad_core_cfg #(.DBG_SEL(tad_pkg::TAD_DBG_SW), .SMALL_DEBUG(1'b1), .TCM_KB(8))
		tad_core_cfg_sm_i (.i_sys_clk, .i_srst, .i_tcm_alias_enable_cfg, .i_fetch_req,
		.i_fetch_addr, .o_fetch_ready(), .o_fetch_valid(), .o_fetch_data(), .o_ext_req(),
		.o_ext_addr(), .i_ext_ack, .i_ext_data, .i_st_req, .i_st_addr, .i_st_data, .i_reg_addr,
		.i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata(sm_rdata), .o_dbg_halted(sm_halted),
		.o_dbg_jtag_en(sm_jtag), .o_dbg_sw_en(sm_sw));
	tad_core_cfg #(.DBG_SEL(tad_pkg::TAD_DBG_NONE), .SMALL_DEBUG(1'b1), .TCM_KB(8))
		tad_core_cfg_nd_i (.i_sys_clk, .i_srst, .i_tcm_alias_enable_cfg, .i_fetch_req,
		.i_fetch_addr, .o_fetch_ready(), .o_fetch_valid(), .o_fetch_data(), .o_ext_req(),
		.o_ext_addr(), .i_ext_ack, .i_ext_data, .i_st_req, .i_st_addr, .i_st_data, .i_reg_addr,
		.i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata(nd_rdata), .o_dbg_halted(nd_halted),
		.o_dbg_jtag_en(nd_jtag), .o_dbg_sw_en(nd_sw));

	// ==============================
	// Bus tasks
	task automatic chk(input bit ok, input string msg);
		n_checks++;
		if (!ok) begin
			fails++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] d);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		@(posedge i_sys_clk);
		chk(o_reg_rdata === d, "register read");
	endtask
	task automatic store(input logic [31:0] a, input logic [31:0] d);
		i_st_req <= 1'b1;
		i_st_addr <= a;
		i_st_data <= d;
		@(posedge i_sys_clk);
		i_st_req <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	// A tight fetch answers two edges after the taking edge, an external one later.
	task automatic fetch(input logic [31:0] a, input logic [31:0] d, input bit tcm);
		int lat;
		lat = 0;
		i_fetch_req <= 1'b1;
		i_fetch_addr <= a;
		@(posedge i_sys_clk);
		i_fetch_req <= 1'b0;
		do begin
			@(posedge i_sys_clk);
			lat++;
		end while (o_fetch_valid !== 1'b1 && lat < 40);
		chk(o_fetch_data === d && (tcm ? lat == 2 : lat > 2), "fetch");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==============================
	// Scenarios
	task automatic t_cfg();
		repeat (2) @(posedge i_sys_clk);
		chk(o_dbg_jtag_en === 1'b1 && o_dbg_sw_en === 1'b1, "ports");
		chk(sm_jtag === 1'b0 && sm_sw === 1'b1, "serial only ports");
		chk(nd_jtag === 1'b0 && nd_sw === 1'b0, "no debug ports");
		reg_rd(8'h08, 32'h0000_2413);
		chk(sm_rdata === 32'h0000_120F, "small cfg");
		chk(nd_rdata === 32'h0000_001B, "no debug cfg");
		reg_wr(8'h08, 32'hFFFF_FFFF);
		reg_rd(8'h08, 32'h0000_2413);
		reg_rd(8'hFC, 32'h0000_0000);
		$display("test cfg done");
	endtask
	task automatic t_copy();
		store(32'h1000_0040, 32'hC0DE_0001);
		fetch(32'h0000_0040, 32'hC0DE_0001, 1'b1);
		fetch(32'h1000_0040, 32'hC0DE_0001, 1'b1);
		store(32'h1000_1FFC, 32'h5A5A_0003);
		fetch(32'h0000_1FFC, 32'h5A5A_0003, 1'b1);
		fetch(32'h0000_2000, 32'hFFFF_DFFF, 1'b0);
		ext_wait <= 4'h0;
		fetch(32'h2000_0000, 32'hDFFF_FFFF, 1'b0);
		$display("test copy done");
	endtask
	task automatic t_bp();
		reg_wr(8'h1C, 32'h1000_0040);
		reg_wr(8'h00, 32'h0000_0008);
		reg_rd(8'h00, 32'h0000_0008);
		chk(sm_rdata === 32'h0000_0008 && nd_rdata === 32'h0, "ctrl others");
		fetch(32'h1000_0040, 32'hC0DE_0001, 1'b1);
		chk(o_dbg_halted === 1'b1, "halt");
		chk(sm_halted === 1'b0 && nd_halted === 1'b0, "unbuilt comparator hit");
		reg_rd(8'h04, 32'h0000_0008);
		reg_wr(8'h04, 32'h0000_0008);
		reg_rd(8'h04, 32'h0000_0000);
		chk(o_dbg_halted === 1'b0, "halt clear");
		reg_wr(8'h20, 32'h3000_0000);
		reg_wr(8'h00, 32'h0000_0010);
		store(32'h3000_0000, 32'h0000_0000);
		reg_rd(8'h04, 32'h0000_0010);
		chk(sm_rdata === 32'h0000_0010 && nd_rdata === 32'h0, "watch others");
		chk(o_dbg_halted === 1'b0, "watch does not halt");
		$display("test breakpoint done");
	endtask
	task automatic t_strap();
		i_srst <= 1'b1;
		i_tcm_alias_enable_cfg <= 2'h2;
		repeat (4) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		reg_rd(8'h08, 32'h0000_2412);
		fetch(32'h0000_0040, 32'hFFFF_FFBF, 1'b0);
		store(32'h1000_0044, 32'hBEEF_0002);
		fetch(32'h1000_0044, 32'hBEEF_0002, 1'b1);
		$display("test strap done");
	endtask

	// Free-running clock and a cycle ceiling against hangs.
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			close_out();
		end
	end
	// Main sequence after four reset cycles with both aliases strapped on.
	initial begin
		{i_srst, i_tcm_alias_enable_cfg, ext_wait} = {1'b1, 2'h3, 4'h3};
		{i_fetch_req, i_st_req, i_reg_wr, i_reg_rd} = 4'h0;
		{i_fetch_addr, i_st_addr, i_st_data, i_reg_wdata} = 128'h0;
		i_reg_addr = 8'h00;
		repeat (4) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		t_cfg();
		t_copy();
		t_bp();
		t_strap();
		close_out();
	end
endmodule

bind tad_core_cfg tad_core_cfg_checker #(.DBG_SEL(DBG_SEL), .TCM_KB(TCM_KB)) chk_i (.i_sys_clk,
	.i_srst, .i_tcm_alias_enable_cfg, .i_fetch_req, .i_fetch_addr, .o_fetch_ready,
	.o_fetch_valid, .o_fetch_data, .o_ext_req, .o_ext_addr, .i_ext_ack, .i_ext_data,
	.i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_dbg_halted, .o_dbg_jtag_en, .o_dbg_sw_en);
